// [hdl/ebm_client.sv]
// external bus mastership client: request, grant, busy, strobe and bus clock
`include "ebm_params.svh"

module ebm_client
	import ebm_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_out_clk,
	input wire logic i_bus_grant_in_n,
	input wire logic i_bus_busy_line_n,
	input wire logic i_ext_access_req,
	input wire logic i_low_power,
	input wire logic i_request_hold_bit,
	input wire logic i_mastership_enable_bit,
	input wire logic i_address_trace_enable_bit,
	output logic o_bus_request_out_n,
	output logic o_bus_busy_line_n,
	output logic o_bus_busy_line_oe,
	output logic o_cas_n,
	output logic o_cas_oe,
	output logic o_bus_clk,
	output logic o_bus_clk_oe,
	output logic o_bus_clk_n,
	output logic o_bus_clk_n_oe,
	output logic o_is_master,
	output logic o_cycle_done
);

	logic [`EBM_SYNC_N-1:0] pin_raw;
	logic [`EBM_SYNC_N-1:0] sync1_reg;
	logic [`EBM_SYNC_N-1:0] sync2_reg;
	logic out_clk_prev_reg;
	logic grant_smp_reg;
	logic busy_idle_smp_reg;
	logic req_reg;
	logic req_next;
	ebm_state_t state_reg;
	ebm_state_t state_next;
	logic [`EBM_CYC_W-1:0] cyc_cnt_reg;
	logic [`EBM_CYC_W-1:0] cyc_cnt_next;
	logic cyc_active_reg;
	logic cyc_active_next;
	logic [`EBM_PHASE_W-1:0] phase_reg;
	logic [`EBM_PHASE_W-1:0] phase_sum;
	logic out_rise;
	logic cyc_last;
	logic cyc_start;
	logic release_ok;
	logic master_next;
	logic drive_busy_next;
	logic bclk_next;

	assign pin_raw = {i_bus_busy_line_n, ~i_bus_grant_in_n, i_out_clk};

	// two flops per pin; only the second stage is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < `EBM_SYNC_N; gi++) begin : g_sync
			always_ff @(posedge i_ref_clk) begin
				if (i_rst) begin
					sync1_reg[gi] <= (gi == `EBM_SYNC_BUSY);
					sync2_reg[gi] <= (gi == `EBM_SYNC_BUSY);
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign out_rise = sync2_reg[`EBM_SYNC_OUT_CLK] & ~out_clk_prev_reg;

	// handshake inputs latched once per output clock, decisions use these
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			out_clk_prev_reg <= 1'b0;
			grant_smp_reg <= 1'b0;
			busy_idle_smp_reg <= 1'b1;
		end else begin
			out_clk_prev_reg <= sync2_reg[`EBM_SYNC_OUT_CLK];
			if (out_rise) begin
				grant_smp_reg <= sync2_reg[`EBM_SYNC_GRANT];
				busy_idle_smp_reg <= sync2_reg[`EBM_SYNC_BUSY];
			end
		end
	end

	// request never looks at mastership, so parking may drop it
	assign req_next = i_low_power ? (i_request_hold_bit & req_reg)
		: (i_ext_access_req | i_request_hold_bit);

	// bus cycle bookkeeping
	assign cyc_last = cyc_active_reg && (cyc_cnt_reg == `EBM_CYC_W'(`EBM_CYCLE_LEN - 1));
	assign cyc_start = (state_reg == EBM_ST_MASTER) && grant_smp_reg && i_ext_access_req
		&& (!cyc_active_reg || cyc_last);
	assign release_ok = !cyc_active_reg || cyc_last;

	always_comb begin
		state_next = state_reg;
		if (out_rise) begin
			case (state_reg)
				EBM_ST_SLAVE: begin
					if (req_reg && grant_smp_reg) begin
						state_next = EBM_ST_WAIT;
					end
				end
				EBM_ST_WAIT: begin
					if (!grant_smp_reg) begin
						state_next = EBM_ST_SLAVE;
					end else if (busy_idle_smp_reg) begin
						state_next = EBM_ST_MASTER;
					end
				end
				EBM_ST_MASTER: begin
					// parked while grant stays, whatever the request does
					if (!grant_smp_reg && release_ok) begin
						state_next = EBM_ST_RELEASE;
					end
				end
				EBM_ST_RELEASE: begin
					state_next = EBM_ST_SLAVE;
				end
				default: begin
					state_next = EBM_ST_SLAVE;
				end
			endcase
		end
	end

	always_comb begin
		cyc_active_next = cyc_active_reg;
		cyc_cnt_next = cyc_cnt_reg;
		if (out_rise) begin
			if (cyc_start) begin
				cyc_active_next = 1'b1;
				cyc_cnt_next = '0;
			end else if (cyc_last) begin
				cyc_active_next = 1'b0;
				cyc_cnt_next = '0;
			end else if (cyc_active_reg) begin
				cyc_cnt_next = cyc_cnt_reg + `EBM_CYC_W'(1);
			end
		end
	end

	assign master_next = (state_next == EBM_ST_MASTER);
	assign drive_busy_next = master_next || (state_next == EBM_ST_RELEASE);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_reg <= EBM_ST_SLAVE;
			req_reg <= 1'b0;
			cyc_active_reg <= 1'b0;
			cyc_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cyc_active_reg <= cyc_active_next;
			cyc_cnt_reg <= cyc_cnt_next;
			if (out_rise) begin
				req_reg <= req_next;
			end
		end
	end

	// pins: busy low as master, high for one period on release, then floated
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_bus_request_out_n <= 1'b1;
			o_bus_busy_line_n <= 1'b1;
			o_bus_busy_line_oe <= 1'b0;
			o_cas_n <= 1'b1;
			o_cas_oe <= 1'b0;
			o_is_master <= 1'b0;
			o_cycle_done <= 1'b0;
		end else begin
			o_bus_request_out_n <= out_rise ? ~req_next : o_bus_request_out_n;
			o_bus_busy_line_n <= ~master_next;
			o_bus_busy_line_oe <= drive_busy_next;
			o_cas_n <= ~(master_next && cyc_active_next);
			o_cas_oe <= master_next || i_mastership_enable_bit;
			o_is_master <= master_next;
			o_cycle_done <= out_rise && cyc_last;
		end
	end

	// phase of the output clock; assumes a power-of-two period in ref cycles
	assign phase_sum = `EBM_PHASE_W'(phase_reg + `EBM_PHASE_W'(`EBM_PHASE_LAT + `EBM_LEAD_CYCLES));
	assign bclk_next = master_next && i_address_trace_enable_bit && !phase_sum[`EBM_PHASE_W-1];

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			phase_reg <= '0;
			o_bus_clk <= 1'b0;
			o_bus_clk_oe <= 1'b0;
			o_bus_clk_n <= 1'b1;
			o_bus_clk_n_oe <= 1'b0;
		end else begin
			phase_reg <= out_rise ? `EBM_PHASE_W'(1) : `EBM_PHASE_W'(phase_reg + `EBM_PHASE_W'(1));
			o_bus_clk <= bclk_next;
			o_bus_clk_oe <= master_next;
			o_bus_clk_n <= ~bclk_next;
			o_bus_clk_n_oe <= master_next;
		end
	end

	sequence s_release_high;
		o_bus_busy_line_oe && o_bus_busy_line_n;
	endsequence

	sequence s_release_float;
		##[1:12] !o_bus_busy_line_oe;
	endsequence

	a_req_reset_off: assert property (@(posedge i_ref_clk)
		i_rst |=> o_bus_request_out_n && (state_reg == EBM_ST_SLAVE))
		else $error("request or state not cleared by reset");

	a_req_stop_drop: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		out_rise && i_low_power && !i_request_hold_bit |=> o_bus_request_out_n)
		else $error("request kept in stop without hold");

	a_req_stop_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		out_rise && i_low_power && i_request_hold_bit |=> $stable(o_bus_request_out_n))
		else $error("request changed in stop with hold");

	a_req_hold_on: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		out_rise && !i_low_power && i_request_hold_bit |=> !o_bus_request_out_n)
		else $error("hold bit did not assert request");

	a_take_after_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(o_is_master) |-> $past(busy_idle_smp_reg) && $past(grant_smp_reg))
		else $error("mastership taken while bus busy");

	a_master_busy_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_is_master |-> o_bus_busy_line_oe && !o_bus_busy_line_n)
		else $error("master not driving busy");

	a_no_abort_cycle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_reg == EBM_ST_MASTER) && cyc_active_reg && !cyc_last |=> o_is_master)
		else $error("bus cycle aborted");

	a_release_pullup: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$fell(o_is_master) |-> s_release_high ##0 s_release_float)
		else $error("busy not released by active pull-up");

	a_cas_tristate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!master_next && !i_mastership_enable_bit |=> !o_cas_oe && o_cas_n)
		else $error("strobe driven while not master");

	a_bclk_gated: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!o_is_master || !$past(i_address_trace_enable_bit) |-> !o_bus_clk)
		else $error("bus clock toggling without mastership and trace");

	a_bclk_inverse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_bus_clk_n_oe |-> (o_bus_clk_n == !o_bus_clk) && o_is_master)
		else $error("complement clock not inverse while master");

endmodule : ebm_client

// [hdl/ebm_params.svh]
// timing and field constants for the external bus mastership client
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH

// reference clock period in ns
`define EBM_REF_CLK_PERIOD_NS 100
// output clock period in ns
`define EBM_OUT_CLK_PERIOD_NS 800
// reference cycles per output clock period
`define EBM_OUT_CLK_CYCLES (`EBM_OUT_CLK_PERIOD_NS / `EBM_REF_CLK_PERIOD_NS)
// bus clock lead over the output clock, a quarter period, in reference cycles
`define EBM_LEAD_CYCLES ((`EBM_OUT_CLK_PERIOD_NS / 4) / `EBM_REF_CLK_PERIOD_NS)
// width of the phase counter, must hold one output clock period
`define EBM_PHASE_W 3
// reference cycles by which the detected output clock edge trails the pin edge
`define EBM_PHASE_LAT 2
// output clock periods taken by one external bus cycle
`define EBM_CYCLE_LEN 2
// width of the bus cycle counter
`define EBM_CYC_W 2
// synchroniser index of each sampled pin
`define EBM_SYNC_OUT_CLK 0
`define EBM_SYNC_GRANT 1
`define EBM_SYNC_BUSY 2
`define EBM_SYNC_N 3

`endif

// [hdl/ebm_pkg.sv]
// types for the external bus mastership client
package ebm_pkg;
	typedef enum logic [1:0] {
		EBM_ST_SLAVE,
		EBM_ST_WAIT,
		EBM_ST_MASTER,
		EBM_ST_RELEASE
	} ebm_state_t;
endpackage : ebm_pkg

// [test/ebm_arb_model.sv]
// arbiter and competing master model for the bus handshake
module ebm_arb_model (
	input wire logic i_out_clk,
	input wire logic i_grant_cmd,
	input wire logic i_other_busy_cmd,
	input wire logic i_dev_busy_n,
	input wire logic i_dev_busy_oe,
	output logic o_grant_n,
	output logic o_busy_wire_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic grant_reg = 1'b1;
	logic other_busy_reg = 1'b0;
	// both move just after an output clock edge, never between edges
	always @(posedge i_out_clk) begin
		grant_reg <= #1 ~i_grant_cmd;
		other_busy_reg <= #1 i_other_busy_cmd;
	end
	assign o_grant_n = grant_reg;
	// wired busy: any driver low wins, the pull-up holds it high otherwise
	assign o_busy_wire_n = ~((i_dev_busy_oe & ~i_dev_busy_n) | other_busy_reg);
endmodule : ebm_arb_model

// [test/ebm_client_tb.sv]
// self-checking bench for the bus mastership client
module ebm_client_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, out_clk = 1'b0, ext = 1'b0, lp = 1'b0, hold = 1'b0;
	logic me = 1'b0, address_trace_enable_bit = 1'b0, gcmd = 1'b0, ocmd = 1'b0;
	logic grant_n, wire_n, req_n, busy_n, busy_oe, cas_n, cas_oe, bclk, bclk_oe;
	logic bclk_n, bclk_n_oe, master, done;
	int fails = 0, num_checks = 0, n;
	initial forever #50 clk = ~clk;
	// output clock is unrelated in phase to the block clock
	initial begin #137; forever #400 out_clk = ~out_clk; end
	ebm_client ebm_client_inst (.i_ref_clk(clk), .i_rst(rst), .i_out_clk(out_clk),
		.i_bus_grant_in_n(grant_n), .i_bus_busy_line_n(wire_n), .i_ext_access_req(ext),
		.i_low_power(lp), .i_request_hold_bit(hold), .i_mastership_enable_bit(me),
		.i_address_trace_enable_bit(address_trace_enable_bit), .o_bus_request_out_n(req_n),
		.o_bus_busy_line_n(busy_n), .o_bus_busy_line_oe(busy_oe), .o_cas_n(cas_n),
		.o_cas_oe(cas_oe), .o_bus_clk(bclk), .o_bus_clk_oe(bclk_oe), .o_bus_clk_n(bclk_n),
		.o_bus_clk_n_oe(bclk_n_oe), .o_is_master(master), .o_cycle_done(done));
	ebm_arb_model ebm_arb_model_inst (.i_out_clk(out_clk), .i_grant_cmd(gcmd),
		.i_other_busy_cmd(ocmd), .i_dev_busy_n(busy_n), .i_dev_busy_oe(busy_oe),
		.o_grant_n(grant_n), .o_busy_wire_n(wire_n));
	task chk(input logic got, input logic exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			$display("[ERR] %0t %s", $time, msg);
			fails++;
		end
	endtask : chk
	task wt(input int c);
		repeat (c) @(negedge clk);
	endtask : wt
	task test_done();
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task t_reset();
		chk(req_n, 1'b1, "request after reset");
		chk(master, 1'b0, "master after reset");
		chk(busy_oe, 1'b0, "busy driven after reset");
		chk(cas_oe, 1'b0, "strobe driven with enable clear");
		chk(bclk_n_oe, 1'b0, "complement clock driven as slave");
		@(posedge clk) me <= 1'b1;
		wt(2);
		chk(cas_oe, 1'b1, "strobe not driven with enable set");
		chk(cas_n, 1'b1, "strobe active as slave");
	endtask : t_reset
	task t_acquire();
		@(posedge clk) begin ext <= 1'b1; ocmd <= 1'b1; gcmd <= 1'b1; address_trace_enable_bit <= 1'b1; end
		repeat (40) if (req_n !== 1'b0) @(negedge clk);
		chk(req_n, 1'b0, "no request for external access");
		wt(48);
		chk(master, 1'b0, "took bus while busy");
		@(posedge clk) ocmd <= 1'b0;
		repeat (60) if (master !== 1'b1) @(negedge clk);
		chk(master, 1'b1, "no mastership after busy idle");
		wt(1);
		chk(busy_oe & ~busy_n, 1'b1, "master not asserting busy");
		n = 0;
		repeat (16) begin
			wt(1);
			if (bclk_n !== ~bclk || bclk_n_oe !== 1'b1) n = 99;
		end
		chk(n == 0, 1'b1, "complement clock not inverse");
	endtask : t_acquire
	task t_clk(input logic exp_rise);
		logic prev;
		time t0;
		n = 0;
		prev = bclk;
		repeat (16) begin
			wt(1);
			if (prev === 1'b0 && bclk === 1'b1) n++;
			prev = bclk;
		end
		chk(n == (exp_rise ? 2 : 0), 1'b1, "bus clock rise count");
		if (exp_rise) begin
			// quarter of 800 ns is 200 ns, one block clock of slack either way
			@(posedge bclk);
			t0 = $time;
			@(posedge out_clk);
			chk(($time - t0) >= 100 && ($time - t0) <= 300, 1'b1, "bus clock lead wrong");
		end
	endtask : t_clk
	task t_park();
		@(posedge clk) ext <= 1'b0;
		repeat (40) if (req_n !== 1'b1) @(negedge clk);
		chk(req_n, 1'b1, "request kept without need");
		wt(32);
		chk(master & busy_oe & ~busy_n, 1'b1, "parked master lost the bus");
		@(posedge clk) address_trace_enable_bit <= 1'b0;
		wt(8);
		t_clk(1'b0);
		chk(bclk_oe, 1'b1, "bus clock not driven as master");
	endtask : t_park
	task t_release();
		logic early;
		early = 1'b0;
		@(posedge clk) ext <= 1'b1;
		repeat (40) if (cas_n !== 1'b0) @(negedge clk);
		chk(cas_n, 1'b0, "no strobe in bus cycle");
		@(posedge clk) gcmd <= 1'b0;
		// mastership must fall only together with the end-of-cycle pulse
		repeat (40) if (master !== 1'b0) begin
			@(negedge clk);
			if (master === 1'b0 && done !== 1'b1) early = 1'b1;
		end
		chk(early, 1'b0, "bus cycle aborted by grant loss");
		chk(master, 1'b0, "bus kept after grant loss");
		wt(1);
		chk(busy_oe & busy_n, 1'b1, "busy not driven high on release");
		wt(16);
		chk(busy_oe, 1'b0, "busy not released");
		chk(req_n, 1'b0, "no re-request for remaining cycles");
		@(posedge clk) gcmd <= 1'b1;
		repeat (60) if (master !== 1'b1) @(negedge clk);
		chk(master, 1'b1, "no mastership on re-grant");
		@(posedge clk) begin rst <= 1'b1; ext <= 1'b0; gcmd <= 1'b0; end
		wt(3);
		chk(req_n, 1'b1, "reset kept request");
		chk(master, 1'b0, "reset kept mastership");
		@(posedge clk) rst <= 1'b0;
	endtask : t_release
	task t_hold();
		@(posedge clk) hold <= 1'b1;
		repeat (40) if (req_n !== 1'b0) @(negedge clk);
		chk(req_n, 1'b0, "hold bit did not request");
		@(posedge clk) lp <= 1'b1;
		wt(32);
		chk(req_n, 1'b0, "hold bit did not keep request in stop");
		@(posedge clk) hold <= 1'b0;
		wt(32);
		chk(req_n, 1'b1, "request kept in stop without hold");
		@(posedge clk) ext <= 1'b1;
		wt(32);
		chk(req_n, 1'b1, "request raised in stop without hold");
		@(posedge clk) lp <= 1'b0;
		repeat (40) if (req_n !== 1'b0) @(negedge clk);
		chk(req_n, 1'b0, "no request after stop");
	endtask : t_hold
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wt(2);
		t_reset();
		t_acquire();
		t_clk(1'b1);
		t_park();
		t_release();
		t_hold();
		test_done();
	end
	initial begin
		#800000;
		fails++;
		test_done();
	end
endmodule : ebm_client_tb
